// >>> hdl/trm_params.svh
// constants for the trip relay i/o mapper
`ifndef TRM_PARAMS_SVH
`define TRM_PARAMS_SVH
`define TRM_CLK_HZ 10000000
`define TRM_DEBOUNCE_US 10000
`define TRM_DEBOUNCE_CYC ((`TRM_CLK_HZ / 1000000) * `TRM_DEBOUNCE_US)
`define TRM_BELL_PULSE_US 5000
`define TRM_BELL_PULSE_CYC ((`TRM_CLK_HZ / 1000000) * `TRM_BELL_PULSE_US)
`define TRM_CMD_AUX_ON 8'h6F
`define TRM_GRP_W 4
`define TRM_IN_W 2
`endif

// >>> hdl/trm_pkg.sv
// types for the trip relay i/o mapper
package trm_pkg;
    typedef enum logic [3:0] {
        TRM_GRP_NONE, TRM_GRP_EARTH_ALARM, TRM_GRP_OVERCURRENT,
        TRM_GRP_PROT_RELAY, TRM_GRP_CUR_ALARM1, TRM_GRP_CUR_ALARM2,
        TRM_GRP_HEALTH, TRM_GRP_REDUCED, TRM_GRP_EARTH_LATCH,
        TRM_GRP_RESTRICTED, TRM_GRP_STANDBY, TRM_GRP_UNRESTRICTED
    } trm_group_t;
    typedef enum logic [1:0] {
        TRM_IN_OFF, TRM_IN_RESET, TRM_IN_REDUCED, TRM_IN_TRIP
    } trm_input_t;
endpackage

// >>> hdl/trm_debounce.sv
// input synchroniser and debounce filter for one contact
`timescale 1ns/1ps
`default_nettype none
`include "trm_params.svh"
module trm_debounce #(
    parameter int DEBOUNCE_CYC = `TRM_DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // contact
    input wire logic raw,
    output logic level,
    output logic rise
);
    logic s1, s2, s3;
    logic [31:0] count;
    wire agree = (s2 == s3);
    wire differs = agree && (s3 != level);
    wire settled = differs && (count >= DEBOUNCE_CYC - 1);

    always_ff @(posedge clock) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            count <= 32'h0;
            level <= 1'b0;
            rise <= 1'b0;
        end else begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
            // bounce restarts the count, one closure gives one command
            count <= (differs && !settled) ? count + 32'h1 : 32'h0;
            if (settled) begin
                level <= s3;
            end
            rise <= settled && s3;
        end
    end
endmodule // trm_debounce
`default_nettype wire

// >>> hdl/trm_mapper.sv
// output relay, digital input, aux and bell alarm mapping
`timescale 1ns/1ps
`default_nettype none
`include "trm_params.svh"
module trm_mapper #(
    parameter int NUM_OUT = 2,
    parameter int DEBOUNCE_CYC = `TRM_DEBOUNCE_CYC,
    parameter int BELL_PULSE_CYC = `TRM_BELL_PULSE_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // configuration
    input wire logic [`TRM_GRP_W*2-1:0] group_sel,
    input wire logic [`TRM_IN_W*2-1:0] input_sel,
    input wire logic health_polarity_nc,
    input wire logic iec_config,
    input wire logic reduced_fitted,
    input wire logic prot_relay_enabled,
    input wire logic earth_enabled,
    input wire logic fan_cooled,
    input wire logic auto_lockout,
    // protection status
    input wire logic earth_leakage_element,
    input wire logic summed_earth_leakage,
    input wire logic external_sensor_earth_alarm,
    input wire logic fast_trip_element,
    input wire logic slow_overload_element,
    input wire logic delayed_short_circuit_element,
    input wire logic prot_relay_trip,
    input wire logic cur_alarm1,
    input wire logic cur_alarm2,
    input wire logic health_ok,
    input wire logic restricted_earth_fault,
    input wire logic standby_earth_fault,
    input wire logic unrestricted_earth_fault,
    input wire logic reduced_via_link,
    input wire logic cooling_needed,
    // breaker mechanism
    input wire logic flux_shifter_trip,
    input wire logic lockout_extended,
    // serial command
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_aux_off,
    // digital inputs
    input wire logic [1:0] din,
    // outputs
    output logic [1:0] relay_out,
    output logic reduced_energy_mode,
    output logic trip_cmd,
    output logic aux_out,
    output logic lockout_fire,
    output logic bell_alarm
);
    logic [1:0] din_level, din_rise;
    logic [1:0] latch;
    logic aux_cmd;
    logic [31:0] bell_count;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_in
            trm_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_deb (
                .clock(clock),
                .rst(rst),
                .raw(din[gi]),
                .level(din_level[gi]),
                .rise(din_rise[gi])
            );
        end
    endgenerate

    // input 1 assignment overridden when reduced energy fitted
    wire [1:0] sel_in0 = reduced_fitted ? 2'(trm_pkg::TRM_IN_REDUCED)
        : input_sel[1:0];
    wire [1:0] sel_in1 = input_sel[3:2];
    // off assignment matches none of these decodes
    wire reset_req = (din_rise[0] && sel_in0 == 2'(trm_pkg::TRM_IN_RESET))
        || (din_rise[1] && sel_in1 == 2'(trm_pkg::TRM_IN_RESET));
    wire reduced_in = (din_level[0] && sel_in0 == 2'(trm_pkg::TRM_IN_REDUCED))
        || (din_level[1] && sel_in1 == 2'(trm_pkg::TRM_IN_REDUCED));
    wire trip_req = (din_rise[0] && sel_in0 == 2'(trm_pkg::TRM_IN_TRIP))
        || (din_rise[1] && sel_in1 == 2'(trm_pkg::TRM_IN_TRIP));
    wire reduced_now = reduced_in || reduced_via_link;

    // event sources gated by fitted options; of overcurrent, only the earth leakage element is gated
    wire earth_alarm = earth_enabled
        && (summed_earth_leakage || external_sensor_earth_alarm);
    wire overcurrent = fast_trip_element || slow_overload_element
        || delayed_short_circuit_element
        || (earth_enabled && earth_leakage_element);
    wire prot_trip = prot_relay_enabled && prot_relay_trip;
    wire iec_ok = iec_config && earth_enabled;

    logic [3:0] grp [2];
    logic [1:0] src_level, src_latch;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_out
            wire [3:0] raw_grp = group_sel[gi*4 +: 4];
            // output 1 is forced to the reduced energy group when reduced energy fitted
            assign grp[gi] = (gi == 0 && reduced_fitted)
                ? 4'(trm_pkg::TRM_GRP_REDUCED) : raw_grp;
            always_comb begin
                src_level[gi] = 1'b0;
                src_latch[gi] = 1'b0;
                case (trm_pkg::trm_group_t'(grp[gi]))
                    trm_pkg::TRM_GRP_EARTH_ALARM: src_level[gi] = earth_alarm;
                    trm_pkg::TRM_GRP_OVERCURRENT: src_latch[gi] = overcurrent;
                    trm_pkg::TRM_GRP_PROT_RELAY: src_latch[gi] = prot_trip;
                    trm_pkg::TRM_GRP_CUR_ALARM1: src_level[gi] = cur_alarm1;
                    trm_pkg::TRM_GRP_CUR_ALARM2: src_level[gi] = cur_alarm2;
                    trm_pkg::TRM_GRP_HEALTH:
                        src_level[gi] = health_ok ^ health_polarity_nc;
                    trm_pkg::TRM_GRP_REDUCED:
                        src_level[gi] = reduced_fitted && reduced_now;
                    trm_pkg::TRM_GRP_EARTH_LATCH: src_latch[gi] = earth_alarm;
                    trm_pkg::TRM_GRP_RESTRICTED:
                        src_latch[gi] = iec_ok && restricted_earth_fault;
                    trm_pkg::TRM_GRP_STANDBY:
                        src_latch[gi] = iec_ok && standby_earth_fault;
                    trm_pkg::TRM_GRP_UNRESTRICTED:
                        src_latch[gi] = iec_ok && unrestricted_earth_fault;
                    default: src_level[gi] = 1'b0;
                endcase
            end
            // a new trip wins over a reset in the same cycle
            wire next_latch = src_latch[gi] || (latch[gi] && !reset_req);
            always_ff @(posedge clock) begin
                if (rst) begin
                    latch[gi] <= 1'b0;
                    relay_out[gi] <= 1'b0;
                end else if (gi < NUM_OUT) begin
                    latch[gi] <= next_latch;
                    relay_out[gi] <= src_level[gi] || next_latch;
                end else begin
                    latch[gi] <= 1'b0;
                    relay_out[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    wire cmd_on = cmd_valid && cmd_code == `TRM_CMD_AUX_ON;
    wire next_aux_cmd = cmd_on || (aux_cmd && !cmd_aux_off);
    wire bell_busy = bell_count != 32'h0;

    always_ff @(posedge clock) begin
        if (rst) begin
            aux_cmd <= 1'b0;
            aux_out <= 1'b0;
            reduced_energy_mode <= 1'b0;
            trip_cmd <= 1'b0;
            lockout_fire <= 1'b0;
            bell_count <= 32'h0;
            bell_alarm <= 1'b0;
        end else begin
            aux_cmd <= next_aux_cmd;
            aux_out <= next_aux_cmd || (fan_cooled && cooling_needed);
            reduced_energy_mode <= reduced_now;
            trip_cmd <= trip_req;
            lockout_fire <= flux_shifter_trip;
            if (flux_shifter_trip && auto_lockout) begin
                bell_count <= 32'(BELL_PULSE_CYC);
            end else if (bell_busy) begin
                bell_count <= bell_count - 32'h1;
            end
            bell_alarm <= auto_lockout ? (flux_shifter_trip || bell_busy)
                : lockout_extended;
        end
    end

    // a_latch_hold: latched group 2 on output 1 energises the relay the next cycle
    a_latch_hold: assert property (@(posedge clock) disable iff (rst)
        (grp[0] == 4'(trm_pkg::TRM_GRP_OVERCURRENT) && overcurrent)
        |=> relay_out[0]) else $error("overcurrent did not latch");
    a_off_quiet: assert property (@(posedge clock) disable iff (rst)
        (sel_in1 == 2'(trm_pkg::TRM_IN_OFF) && sel_in0 == 2'(trm_pkg::TRM_IN_OFF))
        |=> !trip_cmd) else $error("off input acted");
    a_trip_issue: assert property (@(posedge clock) disable iff (rst)
        trip_req |=> trip_cmd) else $error("trip not issued");
    a_reset_clear: assert property (@(posedge clock) disable iff (rst)
        (reset_req && !src_latch[0]) |=> !latch[0])
        else $error("latch not cleared");
    a_aux_cmd: assert property (@(posedge clock) disable iff (rst)
        cmd_on |=> aux_out) else $error("aux not energised");
    a_lockout_src: assert property (@(posedge clock) disable iff (rst)
        lockout_fire |-> $past(flux_shifter_trip))
        else $error("lockout without flux trip");
    a_bell_manual: assert property (@(posedge clock) disable iff (rst)
        (!auto_lockout ##1 !auto_lockout) |-> bell_alarm == $past(lockout_extended))
        else $error("bell not following button");
    a_prot_gate: assert property (@(posedge clock) disable iff (rst)
        (!prot_relay_enabled && grp[1] == 4'(trm_pkg::TRM_GRP_PROT_RELAY)
        && !latch[1]) |=> !latch[1]) else $error("disabled option drove relay");
    a_reduced_in1: assert property (@(posedge clock) disable iff (rst)
        (reduced_fitted && din_level[0]) |=> reduced_energy_mode)
        else $error("input 1 not engaging reduced mode");
endmodule // trm_mapper
`default_nettype wire

// >>> tb/trm_contacts.sv
// clean contact model standing at the two digital inputs
`timescale 1ns/1ps
`default_nettype none
module trm_contacts (
    // clock
    input wire logic clock,
    // requested closures
    input wire logic [1:0] press,
    // contact levels
    output logic [1:0] din
);
    // no bounce: one edge per closure, so one command per closure
    always_ff @(posedge clock) begin
        din <= press;
    end
endmodule // trm_contacts
`default_nettype wire

// >>> tb/trip_relay_io_mapper_test.sv
// self-checking bench for the relay and input mapper
`timescale 1ns/1ps
`default_nettype none
module trip_relay_io_mapper_test;
    logic clock = 1'b0, rst = 1'b1;
    logic [7:0] group_sel = 8'h00, cmd_code = 8'h00;
    logic [3:0] input_sel = 4'h7, oc = 4'h0;
    logic [2:0] ef = 3'h0;
    logic [1:0] ea = 2'h0, cur = 2'h0, press = 2'h0, din, relay_out;
    logic health_polarity_nc = 0, iec_config = 0, reduced_fitted = 0;
    logic prot_relay_enabled = 0, earth_enabled = 1, fan_cooled = 0;
    logic auto_lockout = 1, prot_relay_trip = 0, health_ok = 0;
    logic cooling_needed = 0, flux_shifter_trip = 0, lockout_extended = 0;
    logic cmd_valid = 0, cmd_aux_off = 0, reduced_via_link = 0;
    logic reduced_energy_mode, trip_cmd, aux_out, lockout_fire, bell_alarm;
    int miscompares = 0, samples_checked = 0, trips = 0, bells = 0, fires = 0;
    always #50 clock = ~clock;
    // pulse counters, so one-cycle outputs are never missed
    always @(posedge clock) begin
        trips <= trips + (trip_cmd === 1'b1);
        bells <= bells + (bell_alarm === 1'b1);
        fires <= fires + (lockout_fire === 1'b1);
    end
    trm_contacts contacts (.clock, .press, .din);
    trm_mapper #(.NUM_OUT(2), .DEBOUNCE_CYC(4), .BELL_PULSE_CYC(8)) dut (
        .clock, .rst, .group_sel, .input_sel, .health_polarity_nc,
        .iec_config, .reduced_fitted, .prot_relay_enabled, .earth_enabled,
        .fan_cooled, .auto_lockout, .earth_leakage_element(oc[3]),
        .summed_earth_leakage(ea[0]), .external_sensor_earth_alarm(ea[1]),
        .fast_trip_element(oc[0]), .slow_overload_element(oc[1]),
        .delayed_short_circuit_element(oc[2]), .prot_relay_trip,
        .cur_alarm1(cur[0]), .cur_alarm2(cur[1]), .health_ok,
        .restricted_earth_fault(ef[0]), .standby_earth_fault(ef[1]),
        .unrestricted_earth_fault(ef[2]), .reduced_via_link,
        .cooling_needed, .flux_shifter_trip, .lockout_extended, .cmd_valid,
        .cmd_code, .cmd_aux_off, .din, .relay_out, .reduced_energy_mode,
        .trip_cmd, .aux_out, .lockout_fire, .bell_alarm);
    task automatic tick();
        @(posedge clock);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // a press long enough to clear sync and debounce
    task automatic press_in(input int k);
        tick();
        press[k] <= 1'b1;
        settle(15);
        tick();
        press[k] <= 1'b0;
        settle(15);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clock);
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        tick();
        group_sel <= 8'h02;
        for (int i = 0; i < 4; i++) begin
            tick();
            oc <= 4'h1 << i;
            tick();
            oc <= 4'h0;
            settle(3);
            chk("overcurrent latch", relay_out, 8'h01);
            press_in(1);
            chk("reset clears", relay_out, 8'h00);
        end
        trips = 0;
        press_in(0);
        chk("trip pulses", trips, 8'h01);
        tick();
        press[0] <= 1'b1;
        tick();
        tick();
        press[0] <= 1'b0;
        settle(15);
        chk("short glitch", trips, 8'h01);
        tick();
        input_sel <= 4'h0;
        oc <= 4'h1;
        tick();
        oc <= 4'h0;
        press_in(0);
        press_in(1);
        chk("off inputs", relay_out, 8'h01);
        chk("off no trip", trips, 8'h01);
        tick();
        input_sel <= 4'h7;
        press_in(1);
        $display("test latch and inputs done");
        tick();
        group_sel <= 8'h01;
        for (int i = 0; i < 2; i++) begin
            tick();
            ea <= 2'h1 << i;
            settle(2);
            chk("earth alarm on", relay_out, 8'h01);
            tick();
            ea <= 2'h0;
            settle(2);
            chk("earth alarm off", relay_out, 8'h00);
        end
        tick();
        group_sel <= 8'h08;
        ea <= 2'h2;
        tick();
        ea <= 2'h0;
        settle(3);
        chk("earth latch", relay_out, 8'h01);
        press_in(1);
        tick();
        group_sel <= 8'h54;
        for (int j = 1; j < 4; j++) begin
            tick();
            cur <= j[1:0];
            settle(2);
            chk("current alarms", relay_out, j[7:0]);
        end
        tick();
        cur <= 2'h0;
        group_sel <= 8'h06;
        health_ok <= 1'b1;
        settle(2);
        chk("health open", relay_out, 8'h01);
        tick();
        health_polarity_nc <= 1'b1;
        settle(2);
        chk("health closed", relay_out, 8'h00);
        $display("test level groups done");
        tick();
        group_sel <= 8'h03;
        for (int e = 0; e < 2; e++) begin
            tick();
            prot_relay_enabled <= e[0];
            prot_relay_trip <= 1'b1;
            tick();
            prot_relay_trip <= 1'b0;
            settle(3);
            chk("protective trip", relay_out, e[7:0]);
            press_in(1);
        end
        for (int c = 0; c < 2; c++) begin
            for (int g = 9; g < 12; g++) begin
                tick();
                iec_config <= c[0];
                group_sel <= g[7:0];
                ef <= 3'h1 << (g - 9);
                tick();
                ef <= 3'h0;
                settle(3);
                chk("earth fault", relay_out, c[7:0]);
                press_in(1);
            end
        end
        $display("test latched groups done");
        tick();
        cmd_code <= 8'h6E;
        cmd_valid <= 1'b1;
        tick();
        cmd_valid <= 1'b0;
        settle(2);
        chk("other command", aux_out, 8'h00);
        tick();
        cmd_code <= 8'h6F;
        cmd_valid <= 1'b1;
        tick();
        cmd_valid <= 1'b0;
        settle(2);
        chk("aux on", aux_out, 8'h01);
        tick();
        cmd_aux_off <= 1'b1;
        tick();
        cmd_aux_off <= 1'b0;
        fan_cooled <= 1'b1;
        settle(2);
        chk("aux off", aux_out, 8'h00);
        tick();
        cooling_needed <= 1'b1;
        settle(2);
        chk("fan demand", aux_out, 8'h01);
        // counters cleared off the edge, away from the counting process
        fires = 0;
        bells = 0;
        tick();
        cooling_needed <= 1'b0;
        flux_shifter_trip <= 1'b1;
        tick();
        flux_shifter_trip <= 1'b0;
        settle(20);
        chk("lockout once", fires, 8'h01);
        chk("auto bell span", bells, 8'h09);
        tick();
        auto_lockout <= 1'b0;
        flux_shifter_trip <= 1'b1;
        lockout_extended <= 1'b1;
        tick();
        flux_shifter_trip <= 1'b0;
        settle(12);
        chk("manual bell", bell_alarm, 8'h01);
        tick();
        lockout_extended <= 1'b0;
        settle(2);
        chk("manual bell off", bell_alarm, 8'h00);
        $display("test aux and lockout done");
        trips = 0;
        tick();
        reduced_fitted <= 1'b1;
        group_sel <= 8'h00;
        press[0] <= 1'b1;
        settle(15);
        chk("reduced engaged", reduced_energy_mode, 8'h01);
        chk("reduced relay", relay_out, 8'h01);
        chk("input1 no trip", trips, 8'h00);
        tick();
        press[0] <= 1'b0;
        settle(15);
        chk("reduced released", reduced_energy_mode, 8'h00);
        chk("reduced relay off", relay_out, 8'h00);
        tick();
        reduced_via_link <= 1'b1;
        settle(2);
        chk("link reduced", reduced_energy_mode, 8'h01);
        chk("link relay", relay_out, 8'h01);
        tick();
        reduced_via_link <= 1'b0;
        reduced_fitted <= 1'b0;
        earth_enabled <= 1'b0;
        group_sel <= 8'h01;
        ea <= 2'h1;
        settle(2);
        chk("earth disabled", relay_out, 8'h00);
        tick();
        ea <= 2'h0;
        $display("test reduced energy done");
        finish_test();
    end
endmodule // trip_relay_io_mapper_test
`default_nettype wire
